// file: src/clock_synth_device.sv
`timescale 1ns/1ps
// How it works
// - Data sampled on rising serial clock edges
// - Host sets each bit before rising edge
// - Select low starts, high after 8 or 16 ends
// - Output enable low forces outputs low instantly
// - Outputs selected by config run at programmed frequency
// - Internal loop spans 34 to 68 MHz
// - Fine code tunes loop over one octave
// - Output is loop divided by power of two
// - f = 2^exp * 2078 / (2 - fine/1024)
// - Exponent is unsigned four bits, 0 to 15
// - Each exponent value selects one octave
// - Host derives exponent from log of target
// - Host derives fine code from target frequency
// - Sixteen bits, MSB first, exp/fine/config fields
// - Every eighth edge commits the last byte
// - Config: both antiphase, aux, main, powered down
// - Power-up clears every setting bit
module clock_synth_device (
  input wire logic CLK,
  input wire logic RST_B,
  clock_synth_if.device LINK,
  output logic [3:0] DIVIDER_EXPONENT,
  output logic [9:0] FINE_CODE,
  output logic [1:0] OUTPUT_CONFIG
);

  // Link domain, clocked by the serial clock
  logic sel_clear;
  logic [clock_synth_pkg::CNT_W-1:0] bit_cnt;
  logic [clock_synth_pkg::BYTE_W-2:0] shift;
  logic [clock_synth_pkg::BYTE_W-1:0] next_byte;
  logic [clock_synth_pkg::WORD_W-1:0] link_word;
  logic commit_toggle;

  // Counter restarts with every new frame
  assign sel_clear = LINK.port_select_n | ~RST_B;
  assign next_byte = {shift, LINK.sdi};

  always_ff @(posedge LINK.sclk or posedge sel_clear) begin
    if (sel_clear) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge LINK.sclk or negedge RST_B) begin
    if (!RST_B) begin
      shift <= '0;
    end else if (!LINK.port_select_n) begin
      shift <= next_byte[clock_synth_pkg::BYTE_W-2:0];
    end
  end

  // A byte reaches the word only on its last rise; partial bytes are lost
  always_ff @(posedge LINK.sclk or negedge RST_B) begin
    if (!RST_B) begin
      link_word <= clock_synth_pkg::WORD_RESET;
      commit_toggle <= 1'b0;
    end else if (!LINK.port_select_n) begin
      if (bit_cnt == clock_synth_pkg::UPPER_LAST) begin
        link_word[15:8] <= next_byte;
        commit_toggle <= ~commit_toggle;
      end else if (bit_cnt == clock_synth_pkg::LOWER_LAST) begin
        link_word[7:0] <= next_byte;
        commit_toggle <= ~commit_toggle;
      end
    end
  end

  // System domain
  // Only the commit toggle is synchronised; the word is held meanwhile
  // Word is stable for at least seven serial clocks after a toggle
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic word_new;
  logic [clock_synth_pkg::WORD_W-1:0] setting;
  logic [3:0] exponent;
  logic [9:0] fine;
  clock_synth_pkg::output_config_t config_sel;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_meta <= commit_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  assign word_new = tog_sync ^ tog_seen;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      setting <= clock_synth_pkg::WORD_RESET;
    end else if (word_new) begin
      setting <= link_word;
    end
  end

  assign exponent =
    setting[clock_synth_pkg::EXP_HI:clock_synth_pkg::EXP_LO];
  assign fine = setting[clock_synth_pkg::FINE_HI:clock_synth_pkg::FINE_LO];
  assign config_sel = clock_synth_pkg::output_config_t'(
    setting[clock_synth_pkg::CFG_HI:clock_synth_pkg::CFG_LO]);

  // Loop phase step per system clock; 2048 - fine spans one octave
  function automatic logic [clock_synth_pkg::INC_W-1:0] loop_step(
    input logic [9:0] code
  );
    logic [clock_synth_pkg::DEN_W-1:0] den;
    logic [63:0] quot;
    den = clock_synth_pkg::FINE_TWO - {2'b00, code};
    quot = 64'(clock_synth_pkg::LOOP_NUM) / 64'(den);
    loop_step = quot[clock_synth_pkg::INC_W-1:0];
  endfunction

  // Loop runs at 34..68 MHz in fixed point; may advance >1 cycle per tick
  logic [clock_synth_pkg::INC_W-1:0] step;
  logic [clock_synth_pkg::PHASE_W-1:0] loop_phase;
  logic powered_down;
  logic divided;

  // Powered down holds the phase at zero until a new setting arrives
  assign powered_down = (config_sel == clock_synth_pkg::CFG_OFF);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      step <= '0;
    end else begin
      step <= loop_step(fine);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      loop_phase <= '0;
    end else if (powered_down) begin
      loop_phase <= '0;
    end else begin
      loop_phase <= loop_phase +
        {{(clock_synth_pkg::PHASE_W-clock_synth_pkg::INC_W){1'b0}}, step};
    end
  end

  // Divide by 2^(15 - exp): pick the matching phase bit
  function automatic logic divider_tap(
    input logic [clock_synth_pkg::PHASE_W-1:0] phase,
    input logic [3:0] exp_code
  );
    logic [5:0] idx;
    idx = 6'(clock_synth_pkg::PHASE_FRAC + 14) - {2'b00, exp_code};
    divider_tap = phase[idx];
  endfunction

  assign divided = divider_tap(loop_phase, exponent);

  logic main_q;
  logic aux_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      main_q <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      unique case (config_sel)
        clock_synth_pkg::CFG_BOTH: begin
          main_q <= divided;
          aux_q <= ~divided;
        end
        clock_synth_pkg::CFG_AUX: begin
          main_q <= 1'b0;
          aux_q <= divided;
        end
        clock_synth_pkg::CFG_MAIN: begin
          main_q <= divided;
          aux_q <= 1'b0;
        end
        clock_synth_pkg::CFG_OFF: begin
          main_q <= 1'b0;
          aux_q <= 1'b0;
        end
      endcase
    end
  end

  // Gate without a clock so output enable acts at once
  assign LINK.main_clk = main_q & LINK.out_enable;
  assign LINK.aux_clk = aux_q & LINK.out_enable;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DIVIDER_EXPONENT <= '0;
      FINE_CODE <= '0;
      OUTPUT_CONFIG <= '0;
    end else begin
      DIVIDER_EXPONENT <= exponent;
      FINE_CODE <= fine;
      OUTPUT_CONFIG <= config_sel;
    end
  end

endmodule

// file: src/clock_synth_pkg.sv
package clock_synth_pkg;
  // Setting word layout, first bit on the wire is bit 15
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 12;
  localparam int FINE_HI = 11;
  localparam int FINE_LO = 2;
  localparam int CFG_HI = 1;
  localparam int CFG_LO = 0;
  localparam logic [3:0] UPPER_LAST = 4'h7;
  localparam logic [3:0] LOWER_LAST = 4'hf;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CFG_BOTH = 2'h0,
    CFG_AUX = 2'h1,
    CFG_MAIN = 2'h2,
    CFG_OFF = 2'h3
  } output_config_t;

  // Frequency law: f = 2^exp * BASE_HZ / (2 - fine / FINE_SPAN)
  localparam longint BASE_HZ = 2078;
  localparam int FINE_BITS = 10;
  localparam int LOOP_TOP_EXP = 15;
  localparam longint CLK_HZ = 40_000_000;
  localparam int PHASE_FRAC = 24;
  localparam int PHASE_W = PHASE_FRAC + LOOP_TOP_EXP;
  localparam int INC_W = 26;
  localparam int DEN_W = FINE_BITS + 2;
  localparam logic [DEN_W-1:0] FINE_TWO = 12'h800;
  // Loop cycles per system clock, scaled by 2^PHASE_FRAC, times 2048
  localparam longint LOOP_NUM =
    (BASE_HZ << (LOOP_TOP_EXP + FINE_BITS + PHASE_FRAC)) / CLK_HZ;

  // Host command registers
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_SETTING = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam int CTRL_START = 0;
  localparam int CTRL_UPPER = 1;
  localparam int CTRL_OE = 2;
  localparam int STATUS_BUSY = 0;

  // Host link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CKHI_NS = 25;
  localparam int T_FCK_NS = 20;
  localparam int T_LCH_NS = 400;
  localparam int HALF_CYCLES = (T_CKHI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FCK_CYCLES = (T_FCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LCH_CYCLES = (T_LCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIM_W = 5;
endpackage

// file: src/clock_synth_if.sv
`timescale 1ns/1ps
interface clock_synth_if;
  logic port_select_n;
  logic sclk;
  logic sdi;
  logic out_enable;
  logic main_clk;
  logic aux_clk;

  modport device (
    input port_select_n,
    input sclk,
    input sdi,
    input out_enable,
    output main_clk,
    output aux_clk
  );

  modport host (
    output port_select_n,
    output sclk,
    output sdi,
    output out_enable,
    input main_clk,
    input aux_clk
  );
endinterface

// file: src/clock_synth_host.sv
`timescale 1ns/1ps
module clock_synth_host (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  clock_synth_if.host LINK
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_GAP = 4'b1000
  } host_state_t;

  host_state_t state;
  logic [15:0] setting_word;
  logic oe;
  logic start_req;
  logic upper_req;
  logic upper_only;
  logic [15:0] shift;
  logic [3:0] bit_cnt;
  logic [3:0] last_bit;
  logic [4:0] timer;
  logic sclk_q;
  logic sel_n_q;
  logic sdi_q;
  logic busy;

  assign busy = (state != ST_IDLE);
  assign start_req = WR_STB && (ADDR == clock_synth_pkg::ADDR_CTRL) &&
    WR_DATA[clock_synth_pkg::CTRL_START];
  assign upper_req = WR_DATA[clock_synth_pkg::CTRL_UPPER];
  assign last_bit = upper_only ? clock_synth_pkg::UPPER_LAST :
    clock_synth_pkg::LOWER_LAST;

  // Exponent and fine code are worked out by software
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      setting_word <= '0;
      oe <= 1'b1;
    end else if (WR_STB) begin
      if (ADDR == clock_synth_pkg::ADDR_SETTING) begin
        setting_word <= WR_DATA;
      end else if (ADDR == clock_synth_pkg::ADDR_CTRL) begin
        oe <= WR_DATA[clock_synth_pkg::CTRL_OE];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= '0;
    end else if (RD_STB) begin
      unique case (ADDR)
        clock_synth_pkg::ADDR_SETTING: RD_DATA <= setting_word;
        clock_synth_pkg::ADDR_CTRL: RD_DATA <= {13'h0, oe, upper_only, 1'b0};
        clock_synth_pkg::ADDR_STATUS: RD_DATA <= {15'h0, busy};
        default: RD_DATA <= '0;
      endcase
    end else begin
      RD_DATA <= '0;
    end
  end

  // Serial clock made here by dividing the system clock
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      shift <= '0;
      bit_cnt <= '0;
      timer <= '0;
      upper_only <= 1'b0;
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
      sdi_q <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_req) begin
            sel_n_q <= 1'b0;
            sdi_q <= setting_word[15];
            shift <= {setting_word[14:0], 1'b0};
            upper_only <= upper_req;
            bit_cnt <= '0;
            timer <= '0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (timer == 5'(clock_synth_pkg::FCK_CYCLES - 1)) begin
            timer <= '0;
            state <= ST_SHIFT;
          end else begin
            timer <= timer + 5'h1;
          end
        end
        ST_SHIFT: begin
          if (timer == 5'(clock_synth_pkg::HALF_CYCLES - 1)) begin
            timer <= '0;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              if (bit_cnt == last_bit) begin
                sel_n_q <= 1'b1;
                sdi_q <= 1'b0;
                state <= ST_GAP;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                sdi_q <= shift[15];
                shift <= {shift[14:0], 1'b0};
              end
            end
          end else begin
            timer <= timer + 5'h1;
          end
        end
        ST_GAP: begin
          if (timer == 5'(clock_synth_pkg::LCH_CYCLES - 1)) begin
            timer <= '0;
            state <= ST_IDLE;
          end else begin
            timer <= timer + 5'h1;
          end
        end
      endcase
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.port_select_n = sel_n_q;
  assign LINK.sdi = sdi_q;
  assign LINK.out_enable = oe;

endmodule

// file: tb/clock_synth_asserts.sv
`timescale 1ns/1ps
module clock_synth_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic out_enable,
  input wire logic main_clk,
  input wire logic aux_clk
);
  logic [4:0] n_rise;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Rising serial clocks seen in the current frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      n_rise <= 5'h00;
    end else if ($fell(port_select_n)) begin
      n_rise <= 5'h00;
    end else if (!port_select_n && $rose(sclk)) begin
      n_rise <= n_rise + 5'h01;
    end
  end
  a_oe_gates: assert property (!out_enable |->
    !main_clk && !aux_clk) else $error("outputs not gated");
  a_outs_apart: assert property (!(main_clk && aux_clk))
    else $error("both outputs high");
  a_sclk_idle: assert property (port_select_n |-> !sclk)
    else $error("serial clock outside frame");
  a_first_lead: assert property ($fell(port_select_n) |-> !sclk)
    else $error("no lead before first clock");
  a_sdi_steady: assert property (sclk |-> $stable(sdi))
    else $error("data moved while clock high");
  a_frame_count: assert property ($rose(port_select_n) |->
    n_rise == 5'h08 || n_rise == 5'h10) else $error("bad bit count");
  a_latch_gap: assert property ($rose(port_select_n) |->
    port_select_n[*8]) else $error("gap too short");
  a_frame_hold: assert property ($fell(port_select_n) |->
    !port_select_n[*8]) else $error("frame too short");
  c_upper: cover property ($rose(port_select_n) && n_rise == 5'h08);
  c_full: cover property ($rose(port_select_n) && n_rise == 5'h10);
  c_gated: cover property (!out_enable);
  c_aux: cover property ($rose(aux_clk));
endmodule

// file: tb/serial_programmed_clock_synth_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD %0t got %0h want %0h", $time, g, e); \
  end \
end
module serial_programmed_clock_synth_tb;
  logic clk;
  logic rst_b;
  logic [3:0] addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rd_data;
  logic [3:0] dev_exp;
  logic [9:0] dev_fine;
  logic [1:0] dev_cfg;
  logic [15:0] cur;
  int n_mismatch;
  int checks_done;
  clock_synth_if link_if();
  clock_synth_host clock_synth_host_inst (.CLK(clk), .RST_B(rst_b),
    .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RD_DATA(rd_data), .LINK(link_if));
  clock_synth_device clock_synth_device_inst (.CLK(clk), .RST_B(rst_b),
    .LINK(link_if), .DIVIDER_EXPONENT(dev_exp), .FINE_CODE(dev_fine),
    .OUTPUT_CONFIG(dev_cfg));
  clock_synth_asserts clock_synth_asserts_inst (.CLK(clk), .RST_B(rst_b),
    .port_select_n(link_if.port_select_n), .sclk(link_if.sclk),
    .sdi(link_if.sdi), .out_enable(link_if.out_enable),
    .main_clk(link_if.main_clk), .aux_clk(link_if.aux_clk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask
  // Load a word over the link and wait for the host to go idle
  task automatic send(input logic [15:0] w, input logic up);
    logic [15:0] s;
    int i;
    wr(clock_synth_pkg::ADDR_SETTING, w);
    wr(clock_synth_pkg::ADDR_CTRL, {13'h0000, 1'b1, up, 1'b1});
    s = 16'h0001;
    for (i = 0; i < 200 && s[0] !== 1'b0; i++) begin
      rd(clock_synth_pkg::ADDR_STATUS, s);
    end
    if (s[0] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
    cur = up ? {w[15:8], cur[7:0]} : w;
    repeat (4) @(posedge clk);
    `CHK({dev_exp, dev_fine, dev_cfg}, cur)
  endtask
  task automatic watch(input int n, output int mr, output int ar,
    output int anti);
    logic pm;
    logic pa;
    mr = 0;
    ar = 0;
    anti = 0;
    @(negedge clk);
    pm = link_if.main_clk;
    pa = link_if.aux_clk;
    repeat (n) begin
      @(negedge clk);
      if (link_if.main_clk === 1'b1 && pm === 1'b0) mr++;
      if (link_if.aux_clk === 1'b1 && pa === 1'b0) ar++;
      if (link_if.aux_clk !== ~link_if.main_clk) anti++;
      pm = link_if.main_clk;
      pa = link_if.aux_clk;
    end
  endtask
  task automatic t_reset;
    int mr, ar, anti;
    `CHK({dev_exp, dev_fine, dev_cfg}, 16'h0000)
    watch(64, mr, ar, anti);
    `CHK(anti, 0)
  endtask
  task automatic t_load;
    logic [15:0] r;
    send(16'hcb0c, 1'b0);
    send(16'h3eff, 1'b1);
    rd(clock_synth_pkg::ADDR_SETTING, r);
    `CHK(r, 16'h3eff)
  endtask
  task automatic t_cfg;
    int k, mr, ar, anti;
    logic [1:0] c;
    for (k = 0; k < 4; k++) begin
      c = k[1:0];
      send({4'hd, 10'h000, c}, 1'b0);
      watch(64, mr, ar, anti);
      `CHK(mr > 0, !c[0])
      `CHK(ar > 0, !c[1])
      if (c == 2'h0) `CHK(anti, 0)
    end
  endtask
  task automatic t_oe;
    int mr, ar, anti;
    send(16'hd000, 1'b0);
    wr(clock_synth_pkg::ADDR_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    watch(32, mr, ar, anti);
    `CHK(mr + ar, 0)
    wr(clock_synth_pkg::ADDR_CTRL, 16'h0004);
    repeat (2) @(posedge clk);
    watch(32, mr, ar, anti);
    `CHK(mr > 0 && ar > 0, 1'b1)
  endtask
  task automatic t_freq;
    int ex[4] = '{9, 10, 10, 12};
    int fn[4] = '{512, 0, 1023, 707};
    int i, mr, ar, anti;
    real f, d;
    for (i = 0; i < 4; i++) begin
      send({ex[i][3:0], fn[i][9:0], 2'h2}, 1'b0);
      watch(4000, mr, ar, anti);
      f = (2.0 ** ex[i]) * 2078.0 / (2.0 - fn[i] / 1024.0);
      d = mr - 4000.0 * f / 40.0e6;
      `CHK(d < 2.5 && d > -2.5, 1'b1)
    end
  endtask
  initial begin
    rst_b = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cur = 16'h0000;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_load();
    t_cfg();
    t_oe();
    t_freq();
    end_sim();
  end
endmodule
